// file: sync_burst_sram_command_decode.sv
// Purpose: synchronous burst sram command decode with its storage array
// Assumes: all sram pins but output enable pass two flip-flops, so commands act two edges late
// Notes: mode selects live in a control register reached over ahb-lite
`timescale 1ns/1ps

// Operation
// (R1) global write low writes every lane
// (R2) byte write writes only enabled lanes
// (R3) reads drive all lanes regardless of enables
// (R4) data pins released during every write
// (R5) lanes c, d only on wide variant
// (R6) deselect decode turns drivers off
// (R7) selected processor strobe starts read burst
// (R8) controller strobe starts read or write burst
// (R9) advance low steps to next address
// (R10) advance high repeats current address
// (R11) output enable high disables drivers asynchronously
// (R12) controller may tie strobes for non-burst
// (R13) controller may use controller strobe alone
// (R14) dummy read advances counter like read
// (R15) controller waits for drivers off before writing
// (R16) low address bits preset linear/interleaved counter
// (R17) counter wraps to start after four
// (R18) flow-through select bypasses output register
// (R19) deselect depth selects single or dual
// (R20) begin burst reloads counter, drops old burst
module sync_burst_sram_command_decode (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // sram control pins
   input wire logic select_one_n,
   input wire logic select_two,
   input wire logic select_three_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic global_write_n,
   input wire logic byte_write_n,
   input wire logic lane_a_write_en_n,
   input wire logic lane_b_write_en_n,
   input wire logic lane_c_write_en_n,
   input wire logic lane_d_write_en_n,
   input wire logic output_en_n,
   // sram address and data pins
   input wire logic [sram_decode_pkg::ADDR_W-1:0] sram_addr,
   input wire logic [sram_decode_pkg::DATA_W-1:0] dq_in,
   output logic [sram_decode_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe_n
);

   logic [sram_decode_pkg::DATA_W-1:0] mem [sram_decode_pkg::DEPTH];

   sram_decode_pkg::pins_s pins_in;
   sram_decode_pkg::pins_s p1_r, p1_nxt;
   sram_decode_pkg::pins_s p2_r, p2_nxt;

   sram_decode_pkg::ctrl_s ctrl_r, ctrl_nxt;
   logic active_r, active_nxt;
   logic [sram_decode_pkg::ADDR_W-1:0] base_r, base_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   sram_decode_pkg::op_e op_r, op_nxt;

   logic rd1_r, rd1_nxt;
   logic rd2_r, rd2_nxt;
   logic desel1_r, desel1_nxt;
   logic wr1_r, wr1_nxt;
   logic [sram_decode_pkg::DATA_W-1:0] out1_r, out1_nxt;
   logic [sram_decode_pkg::DATA_W-1:0] out2_r, out2_nxt;

   logic dph_r, dph_nxt;
   logic dph_wr_r, dph_wr_nxt;
   logic [7:0] dph_addr_r, dph_addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;

   logic sel_full;
   logic deselect;
   logic begin_proc;
   logic begin_ctrl;
   logic cont;
   logic is_write;
   logic [3:0] lane_mask;
   logic [3:0] lane_we;
   logic [1:0] start_lo;
   logic [1:0] acc_lo;
   logic [sram_decode_pkg::ADDR_W-1:0] acc_addr;
   logic do_access;
   logic drive;

   always_comb begin
      pins_in.select_one_n = select_one_n;
      pins_in.select_two = select_two;
      pins_in.select_three_n = select_three_n;
      pins_in.proc_addr_strobe_n = proc_addr_strobe_n;
      pins_in.ctrl_addr_strobe_n = ctrl_addr_strobe_n;
      pins_in.burst_advance_n = burst_advance_n;
      pins_in.global_write_n = global_write_n;
      pins_in.byte_write_n = byte_write_n;
      pins_in.lane_en_n = {lane_d_write_en_n, lane_c_write_en_n,
                           lane_b_write_en_n, lane_a_write_en_n};
      pins_in.addr = sram_addr;
      pins_in.dq = dq_in;
   end

   // command decode and burst state
   always_comb begin
      p1_nxt = pins_in;
      p2_nxt = p1_r;
      active_nxt = active_r;
      base_nxt = base_r;
      cnt_nxt = cnt_r;
      op_nxt = sram_decode_pkg::OP_IDLE;
      lane_we = 4'h0;
      do_access = 1'b0;

      sel_full = !p2_r.select_one_n && p2_r.select_two &&
                 !p2_r.select_three_n;
      deselect = (!p2_r.select_one_n &&
                  (p2_r.select_three_n || !p2_r.select_two) &&
                  (!p2_r.proc_addr_strobe_n ||
                   !p2_r.ctrl_addr_strobe_n)) ||
                 (p2_r.select_one_n && !p2_r.ctrl_addr_strobe_n); // [R6]
      begin_proc = sel_full && !p2_r.proc_addr_strobe_n; // [R7]
      begin_ctrl = sel_full && p2_r.proc_addr_strobe_n &&
                   !p2_r.ctrl_addr_strobe_n; // [R8]
      cont = p2_r.ctrl_addr_strobe_n &&
             (p2_r.proc_addr_strobe_n || p2_r.select_one_n);

      // write-no-bytes still counts as a write, so drivers stay off
      is_write = !p2_r.global_write_n || !p2_r.byte_write_n;
      if (!p2_r.global_write_n) begin
         lane_mask = sram_decode_pkg::LANE_ALL; // [R1]
      end else if (!p2_r.byte_write_n) begin
         lane_mask = ~p2_r.lane_en_n; // [R2]
      end else begin
         lane_mask = 4'h0;
      end
      if (!sram_decode_pkg::WIDE_VARIANT) begin
         lane_mask = lane_mask & sram_decode_pkg::LANE_AB; // [R5]
      end

      start_lo = base_r[1:0];
      if (deselect) begin
         active_nxt = 1'b0;
         op_nxt = sram_decode_pkg::OP_DESEL;
      end else if (begin_proc || begin_ctrl) begin
         // any running burst is dropped on a fresh start
         base_nxt = p2_r.addr; // [R20]
         cnt_nxt = 2'h0; // [R16]
         start_lo = p2_r.addr[1:0];
         active_nxt = 1'b1;
         do_access = 1'b1;
      end else if (cont && active_r) begin
         if (!p2_r.burst_advance_n) begin
            cnt_nxt = 2'(cnt_r + 2'h1); // [R9] [R17] [R14]
         end else begin
            cnt_nxt = cnt_r; // [R10]
         end
         do_access = 1'b1;
      end

      if (ctrl_r.burst_order_sel_n) begin
         acc_lo = start_lo ^ cnt_nxt; // [R16]
      end else begin
         acc_lo = 2'(start_lo + cnt_nxt); // [R16]
      end
      if (begin_proc || begin_ctrl) begin
         acc_addr = {p2_r.addr[sram_decode_pkg::ADDR_W-1:2], acc_lo};
      end else begin
         acc_addr = {base_r[sram_decode_pkg::ADDR_W-1:2], acc_lo};
      end

      if (do_access) begin
         if (begin_proc || !is_write) begin
            op_nxt = sram_decode_pkg::OP_READ; // [R7]
         end else begin
            op_nxt = sram_decode_pkg::OP_WRITE; // [R8]
            lane_we = lane_mask;
         end
      end
   end

   // output pipeline: stage one feeds flow-through, stage two pipeline
   always_comb begin
      rd1_nxt = (op_nxt == sram_decode_pkg::OP_READ);
      wr1_nxt = (op_nxt == sram_decode_pkg::OP_WRITE);
      desel1_nxt = (op_nxt == sram_decode_pkg::OP_DESEL);
      out1_nxt = out1_r;
      if (rd1_nxt) begin
         out1_nxt = mem[acc_addr]; // [R3]
      end
      // not cut here, so dual deselect keeps the last read on the pins
      rd2_nxt = rd1_r;
      out2_nxt = out1_r;
      if (!ctrl_r.flow_through_sel_n) begin
         drive = rd1_r; // [R18]
      end else if (!ctrl_r.deselect_depth_sel) begin
         drive = rd2_r; // [R19]
      end else begin
         // single deselect cuts the drivers one stage ahead of data
         drive = rd2_r && !desel1_r; // [R19]
      end
      drive = drive && !wr1_r; // [R4]
   end

   // output enable acts on the raw pin, so it can cut drivers at any time
   assign dq_oe_n = !drive || output_en_n; // [R11]
   assign dq_out = ctrl_r.flow_through_sel_n ? out2_r : out1_r; // [R18]

   // ahb-lite register slave, zero wait states
   always_comb begin
      dph_nxt = hsel && htrans == sram_decode_pkg::HTRANS_NONSEQ && hready;
      dph_wr_nxt = hwrite;
      dph_addr_nxt = haddr[7:0];
      hrdata_nxt = 32'h0000_0000;
      ctrl_nxt = ctrl_r;
      if (dph_r && dph_wr_r) begin
         if (dph_addr_r == sram_decode_pkg::CTRL_OFFSET) begin
            ctrl_nxt.burst_order_sel_n =
               hwdata[sram_decode_pkg::CTRL_ORDER_BIT];
            ctrl_nxt.flow_through_sel_n =
               hwdata[sram_decode_pkg::CTRL_FLOW_BIT];
            ctrl_nxt.deselect_depth_sel =
               hwdata[sram_decode_pkg::CTRL_DEPTH_BIT];
         end
      end
      if (dph_nxt && !hwrite) begin
         if (haddr[7:0] == sram_decode_pkg::CTRL_OFFSET) begin
            hrdata_nxt[sram_decode_pkg::CTRL_ORDER_BIT] =
               ctrl_r.burst_order_sel_n;
            hrdata_nxt[sram_decode_pkg::CTRL_FLOW_BIT] =
               ctrl_r.flow_through_sel_n;
            hrdata_nxt[sram_decode_pkg::CTRL_DEPTH_BIT] =
               ctrl_r.deselect_depth_sel;
         end else if (haddr[7:0] == sram_decode_pkg::STATUS_OFFSET) begin
            hrdata_nxt[sram_decode_pkg::STAT_CNT_LSB +: 2] = cnt_r;
            hrdata_nxt[sram_decode_pkg::STAT_OP_LSB +: 2] = op_r;
            hrdata_nxt[sram_decode_pkg::STAT_ACTIVE_BIT] = active_r;
         end else if (haddr[7:0] ==
                      sram_decode_pkg::BURST_ADDR_OFFSET) begin
            hrdata_nxt[sram_decode_pkg::ADDR_W-1:0] = base_r;
         end else begin
            hrdata_nxt = 32'h0000_0000;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = sram_decode_pkg::HRESP_OKAY;
   assign hrdata = hrdata_r;

   // storage array has no reset; lanes written one by one
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < sram_decode_pkg::LANES; i++) begin
         if (lane_we[i]) begin
            mem[acc_addr][i*sram_decode_pkg::LANE_W +: sram_decode_pkg::LANE_W]
               <= p2_r.dq[i*sram_decode_pkg::LANE_W +:
                          sram_decode_pkg::LANE_W]; // [R2]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         p1_r <= '1;
         p2_r <= '1;
         // fields placed by bit position, the struct order differs
         ctrl_r.burst_order_sel_n <=
            sram_decode_pkg::CTRL_RESET[sram_decode_pkg::CTRL_ORDER_BIT];
         ctrl_r.flow_through_sel_n <=
            sram_decode_pkg::CTRL_RESET[sram_decode_pkg::CTRL_FLOW_BIT];
         ctrl_r.deselect_depth_sel <=
            sram_decode_pkg::CTRL_RESET[sram_decode_pkg::CTRL_DEPTH_BIT];
         active_r <= 1'b0;
         base_r <= '0;
         cnt_r <= 2'h0;
         op_r <= sram_decode_pkg::OP_IDLE;
         rd1_r <= 1'b0;
         rd2_r <= 1'b0;
         desel1_r <= 1'b0;
         wr1_r <= 1'b0;
         out1_r <= '0;
         out2_r <= '0;
         dph_r <= 1'b0;
         dph_wr_r <= 1'b0;
         dph_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         p1_r <= p1_nxt;
         p2_r <= p2_nxt;
         ctrl_r <= ctrl_nxt;
         active_r <= active_nxt;
         base_r <= base_nxt;
         cnt_r <= cnt_nxt;
         op_r <= op_nxt;
         rd1_r <= rd1_nxt;
         rd2_r <= rd2_nxt;
         desel1_r <= desel1_nxt;
         wr1_r <= wr1_nxt;
         out1_r <= out1_nxt;
         out2_r <= out2_nxt;
         dph_r <= dph_nxt;
         dph_wr_r <= dph_wr_nxt;
         dph_addr_r <= dph_addr_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

endmodule

// file: sram_decode_pkg.sv
// Purpose: shared constants and carriers for the burst sram command decode
// Assumes: 36-bit wide variant, 256-word array, ahb-lite register slave
// Notes: offsets are byte addresses of aligned 32-bit words
package sram_decode_pkg;
   localparam int ADDR_W = 8;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int DATA_W = 36;
   localparam int DEPTH = 256;
   // 1 selects the 32/36-bit variant with lanes c and d, 0 the 18-bit one
   localparam logic WIDE_VARIANT = 1'b1;
   localparam logic [3:0] LANE_ALL = 4'hF;
   localparam logic [3:0] LANE_AB = 4'h3;

   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] BURST_ADDR_OFFSET = 8'h08;

   localparam int CTRL_ORDER_BIT = 0;
   localparam int CTRL_FLOW_BIT = 1;
   localparam int CTRL_DEPTH_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h6;

   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_OP_LSB = 2;
   localparam int STAT_ACTIVE_BIT = 4;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      OP_IDLE,
      OP_DESEL,
      OP_READ,
      OP_WRITE
   } op_e;

   typedef struct packed {
      logic select_one_n;
      logic select_two;
      logic select_three_n;
      logic proc_addr_strobe_n;
      logic ctrl_addr_strobe_n;
      logic burst_advance_n;
      logic global_write_n;
      logic byte_write_n;
      logic [3:0] lane_en_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
   } pins_s;

   typedef struct packed {
      logic burst_order_sel_n;
      logic flow_through_sel_n;
      logic deselect_depth_sel;
   } ctrl_s;
endpackage

// file: sram_ctrl_model.sv
// Purpose: controller side of the sram pins, one command per cycle
// Assumes: the bench hands over whole pin sets
// Notes: a released data bus shows the inverse of the last value
`timescale 1ns/1ps
module sram_ctrl_model (
   // clock
   input wire logic sys_clk,
   // pins toward the device
   output sram_decode_pkg::pins_s pins,
   output logic output_en_n,
   output logic [sram_decode_pkg::DATA_W-1:0] dq_in,
   // device drive
   input wire logic [sram_decode_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe_n
);
   logic drive_r = 1'b0;
   initial begin
      pins = '1;
      output_en_n = 1'b1;
   end
   // the device owns the wire only while it drives
   assign dq_in = !dq_oe_n ? dq_out : (drive_r ? pins.dq : ~pins.dq);
   // strobes may be held for plain or burst use
   task automatic apply(input sram_decode_pkg::pins_s p, input logic o);
      @(posedge sys_clk);
      pins <= p;
      drive_r <= !p.global_write_n || !p.byte_write_n;
      // drivers forced off on the same edge as the write data goes on
      output_en_n <= o || !p.global_write_n || !p.byte_write_n;
   endtask
endmodule

// file: sync_burst_sram_command_decode_sva.sv
// Purpose: pin-level checks of the burst sram command decode
// Assumes: reads show three (flow) or four (pipeline) edges late
// Notes: three-command runs make both output modes agree
`timescale 1ns/1ps
module sync_burst_sram_command_decode_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // sram pins
   input wire logic select_one_n,
   input wire logic select_two,
   input wire logic select_three_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic global_write_n,
   input wire logic byte_write_n,
   input wire logic output_en_n,
   input wire logic dq_oe_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic sel, cbeg, wrq, desel, cont;
   assign sel = !select_one_n && select_two && !select_three_n;
   assign cbeg = sel && proc_addr_strobe_n && !ctrl_addr_strobe_n;
   assign wrq = !global_write_n || !byte_write_n;
   assign cont = ctrl_addr_strobe_n && (proc_addr_strobe_n || select_one_n);
   assign desel = (!select_one_n && (select_three_n || !select_two)
      && (!proc_addr_strobe_n || !ctrl_addr_strobe_n))
      || (select_one_n && !ctrl_addr_strobe_n);
   AST_OE_OFF: assert property (output_en_n |-> dq_oe_n)
      else $error("drivers on with output enable high");
   AST_GW_WRITE: assert property (
      (cbeg && !global_write_n) [*3] |-> ##2 dq_oe_n)
      else $error("global write did not release data");
   AST_BW_WRITE: assert property (
      (cbeg && global_write_n && !byte_write_n) [*3] |-> ##2 dq_oe_n)
      else $error("byte write did not release data");
   AST_DESEL: assert property (desel [*3] |-> ##2 dq_oe_n)
      else $error("deselect left drivers on");
   AST_CTRL_READ: assert property (
      (cbeg && !wrq) [*3] ##2 !output_en_n |-> !dq_oe_n)
      else $error("read did not drive data");
   AST_PROC_READ: assert property (
      (sel && !proc_addr_strobe_n) ##1 (cont && !wrq) [*2]
      ##2 !output_en_n |-> !dq_oe_n)
      else $error("processor strobe read did not drive");
   AST_HOLD_READ: assert property (
      (cbeg && !wrq) ##1 (cont && burst_advance_n && !wrq) [*2]
      ##2 !output_en_n |-> !dq_oe_n)
      else $error("held burst did not drive");
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
endmodule
bind sync_burst_sram_command_decode sync_burst_sram_command_decode_sva chk (
   .sys_clk, .rst_n, .hreadyout, .hresp, .select_one_n, .select_two,
   .select_three_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
   .burst_advance_n, .global_write_n, .byte_write_n, .output_en_n,
   .dq_oe_n);

// file: sync_burst_sram_command_decode_test.sv
// Purpose: self-checking bench for the burst sram command decode
// Assumes: flow data three cycles after the command, pipeline four
// Notes: data slots and driver enables are judged at the pins
`timescale 1ns/1ps
module sync_burst_sram_command_decode_test;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp, output_en_n, dq_oe_n;
   logic [31:0] hrdata, rd;
   logic [sram_decode_pkg::DATA_W-1:0] dq_in, dq_out;
   sram_decode_pkg::pins_s pins;
   sram_decode_pkg::pins_s q[$];
   logic [36:0] ex[$];
   logic oe[$];
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #20 sys_clk = ~sys_clk;
   sram_ctrl_model model (.sys_clk, .pins, .output_en_n, .dq_in, .dq_out,
      .dq_oe_n);
   sync_burst_sram_command_decode dut (.sys_clk, .rst_n, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
      .hresp, .hrdata, .select_one_n(pins.select_one_n),
      .select_two(pins.select_two), .select_three_n(pins.select_three_n),
      .proc_addr_strobe_n(pins.proc_addr_strobe_n),
      .ctrl_addr_strobe_n(pins.ctrl_addr_strobe_n),
      .burst_advance_n(pins.burst_advance_n),
      .global_write_n(pins.global_write_n),
      .byte_write_n(pins.byte_write_n),
      .lane_a_write_en_n(pins.lane_en_n[0]),
      .lane_b_write_en_n(pins.lane_en_n[1]),
      .lane_c_write_en_n(pins.lane_en_n[2]),
      .lane_d_write_en_n(pins.lane_en_n[3]), .output_en_n,
      .sram_addr(pins.addr), .dq_in, .dq_out, .dq_oe_n);
   function automatic logic [35:0] fill(input logic [7:0] a);
      return {4{1'b1, a}};
   endfunction
   task automatic check(input string what, input logic [35:0] seen,
         input logic [35:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= sram_decode_pkg::HTRANS_NONSEQ;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // kind: 0 ctrl begin, 1 proc begin, 2 step, 3 hold, 4..6 deselects
   task automatic add(input int k, input logic [7:0] a, input logic [1:0] w,
         input logic [3:0] ln, input logic [35:0] d, input logic o,
         input logic [36:0] e);
      sram_decode_pkg::pins_s p;
      p = '1;
      p.addr = a;
      p.dq = d;
      p.lane_en_n = ln;
      p.global_write_n = (w != 2'h1);
      p.byte_write_n = (w != 2'h2);
      p.select_one_n = (k == 4);
      p.select_two = (k != 6);
      p.select_three_n = (k == 5);
      p.proc_addr_strobe_n = !(k == 1 || k == 6);
      p.ctrl_addr_strobe_n = !(k == 0 || k >= 4);
      p.burst_advance_n = (k == 3);
      q.push_back(p);
      oe.push_back(o);
      ex.push_back(e);
   endtask
   task automatic play(input int lat);
      int j;
      for (int i = 0; i < q.size() + lat; i++) begin
         if (i < q.size()) model.apply(q[i], oe[i]);
         else model.apply('1, 1'b0);
         @(negedge sys_clk);
         j = i - lat;
         if (i < q.size() && oe[i]) check("oe", dq_oe_n, 1'b1);
         else if (j >= 0 && ex[j][36] === 1'b1) begin
            check("oe", dq_oe_n, 1'b0);
            check("dq", dq_out, ex[j][35:0]);
         end else if (j >= 0) check("oe", dq_oe_n, 1'b1);
      end
      q.delete();
      oe.delete();
      ex.delete();
   endtask
   task automatic t_regs();
      ahb(1'b0, sram_decode_pkg::CTRL_OFFSET, 32'h0000_0000);
      check("ctrl", rd, 36'h0_0000_0006);
      ahb(1'b0, 8'h0C, 32'h0000_0000);
      check("unmapped", rd, 36'h0_0000_0000);
   endtask
   task automatic t_fill();
      logic [7:0] a;
      ahb(1'b1, sram_decode_pkg::CTRL_OFFSET, 32'h0000_0004);
      for (int i = 0; i < 4; i++) add(0, 8'(8'h24 + i), 2'h1, 4'hF,
         fill(8'(8'h24 + i)), 1'b0, 37'h0);
      for (int i = 0; i < 7; i++) begin
         a = 8'(8'h24 + ((i < 3) ? 3 : i - 3));
         add(i == 0 ? 0 : (i < 3 ? 3 : 2), 8'h27, 2'h0, 4'h5, ~fill(a),
            1'b0, {1'b1, fill(a)});
      end
      play(3);
   endtask
   task automatic t_pipe();
      logic [7:0] a;
      ahb(1'b1, sram_decode_pkg::CTRL_OFFSET, 32'h0000_0003);
      for (int i = 0; i < 5; i++) begin
         a = {6'h09, 2'h2 ^ 2'(i % 4)};
         add(i == 0 ? 1 : 2, 8'h26, i == 0 ? 2'h1 : 2'h0, 4'hF, fill(a),
            1'b0, {1'b1, fill(a)});
      end
      // dual deselect: the last read still shows before drivers go off
      add(4, 8'h24, 2'h0, 4'hF, '0, 1'b0, 37'h0);
      play(4);
   endtask
   task automatic t_single();
      ahb(1'b1, sram_decode_pkg::CTRL_OFFSET, 32'h0000_0006);
      add(0, 8'h24, 2'h0, 4'hF, '0, 1'b0, {1'b1, fill(8'h24)});
      // single deselect cuts the read just before it
      add(2, 8'h24, 2'h0, 4'hF, '0, 1'b0, 37'h0);
      add(4, 8'h24, 2'h0, 4'hF, '0, 1'b0, 37'h0);
      play(4);
   endtask
   task automatic t_dummy();
      logic [7:0] a;
      ahb(1'b1, sram_decode_pkg::CTRL_OFFSET, 32'h0000_0004);
      for (int i = 0; i < 5; i++) begin
         a = 8'(8'h24 + (i % 4));
         add(i == 0 ? 0 : 2, 8'h24, 2'h0, 4'hF, fill(a), i < 4,
            {1'b1, fill(a)});
      end
      play(3);
   endtask
   task automatic t_bytes();
      add(0, 8'h25, 2'h2, 4'hD, 36'h0_0000_0000, 1'b0, 37'h0);
      add(0, 8'h24, 2'h2, 4'hF, 36'h0_0000_0000, 1'b0, 37'h0);
      add(0, 8'h27, 2'h2, 4'h3, 36'h0_0000_0000, 1'b0, 37'h0);
      add(0, 8'h24, 2'h0, 4'h0, '0, 1'b0, {1'b1, fill(8'h24)});
      add(0, 8'h25, 2'h0, 4'h0, '0, 1'b0,
         {1'b1, fill(8'h25) & 36'hF_FFFC_01FF});
      add(0, 8'h27, 2'h0, 4'h0, '0, 1'b0,
         {1'b1, fill(8'h27) & 36'h0_0003_FFFF});
      for (int k = 4; k < 7; k++) add(k, 8'h24, 2'h0, 4'hF, '0, 1'b0, 37'h0);
      play(3);
      ahb(1'b0, sram_decode_pkg::BURST_ADDR_OFFSET, 32'h0000_0000);
      check("base", rd, 36'h0_0000_0027);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs();
      t_fill();
      t_pipe();
      t_single();
      t_dummy();
      t_bytes();
      wrap_up();
   end
endmodule
